// ### hdl/ssi_regs.sv
// sleep control, fault flags and identification registers behind spi
`timescale 1ns/1ps
// Notes on behaviour
// - writing 0xff to sleep control low byte enters sleep until woken.
// - chip select falling edge, reset pulse or power cycle wakes.
// - sleep byte 0 to 254 sleeps that many half seconds.
// - fault flags read one on error, zero normally, reset to zero.
// - reading fault flags returns them then clears every flag except supply low bit 0.
// - persisting error sets its flag again at end of next sample.
// - supply low bit 0 follows the monitor, needs no read to clear.
// - spi failure bit 3 sets when clock count is not multiple of 16.
// - bit 9 second alarm, bit 8 first alarm; 15:10 and 7 unused.
// - bit 6 program checksum failure, bit 5 self-test failure.
// - bit 4 overrange, bit 2 flash update failure, bit 1 unused.
// - part number register returns a fixed read-only code.
// - three read-only lot registers return factory lot codes.
// - serial register holds 14-bit value in 13:0, top bits zero.
// - lot registers sit at byte addresses 0x32, 0x34 and 0x36.
module ssi_regs #(
    parameter int STEP_CYCLES = ssi_pkg::SLEEP_STEP_CYCLES,
    // arbitrary identification values, replaced by factory programming
    parameter logic [15:0] PART_CODE = 16'h1234,
    parameter logic [15:0] LOT_FIRST = 16'h0001,
    parameter logic [15:0] LOT_SECOND = 16'h0002,
    parameter logic [15:0] LOT_THIRD = 16'h0003,
    parameter logic [13:0] SERIAL_CODE = 14'h0001
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic i_sample_tick,
    input wire logic i_supply_low,
    input wire logic i_flash_fail,
    input wire logic i_overrange,
    input wire logic i_self_test_fail,
    input wire logic i_checksum_fail,
    input wire logic i_alarm1,
    input wire logic i_alarm2,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic o_sleep,
    output logic [15:0] o_fault_flags
);
    typedef enum logic [1:0] {
        AWAKE = 2'b00,
        SLEEP_HOLD = 2'b01,
        SLEEP_TIMED = 2'b10
    } ssi_power_t;

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    ssi_spi_if spi ();

    ssi_power_t pwr_q, pwr_d;
    logic [7:0] sleep_ctl_q;
    logic [15:0] flags_q, flags_d;
    logic [15:0] flag_set;
    logic [15:0] flag_cond;
    logic [15:0] tx_q, tx_d;
    logic timer_done;

    // reset release is synchronised; asserting stays asynchronous
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    ssi_spi_slave u_spi (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_din(i_din),
        .o_dout(o_dout),
        .o_dout_oe_n(o_dout_oe_n),
        .bus(spi.slave)
    );

    // command word decode: bit 15 write, 14:8 byte address, 7:0 data
    function automatic logic hits(input logic [6:0] addr,
                                  input logic [6:0] ofs);
        hits = ({addr[6:1], 1'b0} == ofs);
    endfunction : hits

    wire cmd_write = spi.word[15];
    wire [6:0] cmd_addr = spi.word[14:8];
    wire [7:0] cmd_data = spi.word[7:0];
    wire cmd_read = spi.word_valid & ~cmd_write;

    // only the low byte holds sleep settings; upper byte writes are dropped
    wire sleep_wr = spi.word_valid & cmd_write
        & (cmd_addr == ssi_pkg::SLEEP_CONTROL_OFS);
    wire sleep_forever = (cmd_data == ssi_pkg::SLEEP_FOREVER);
    wire sleep_timed_go = sleep_wr & ~sleep_forever;
    wire flags_rd = cmd_read
        & hits(cmd_addr, ssi_pkg::FAULT_FLAGS_OFS);

    wire rd_sleep = hits(cmd_addr, ssi_pkg::SLEEP_CONTROL_OFS);
    wire rd_flags = hits(cmd_addr, ssi_pkg::FAULT_FLAGS_OFS);
    wire rd_lot1 = hits(cmd_addr, ssi_pkg::LOT_CODE_FIRST_OFS);
    wire rd_lot2 = hits(cmd_addr, ssi_pkg::LOT_CODE_SECOND_OFS);
    wire rd_lot3 = hits(cmd_addr, ssi_pkg::LOT_CODE_THIRD_OFS);
    wire rd_part = hits(cmd_addr, ssi_pkg::PART_NUMBER_OFS);
    wire rd_serial = hits(cmd_addr, ssi_pkg::UNIT_SERIAL_OFS);

    wire [15:0] serial_word = {2'b00, SERIAL_CODE};
    wire [15:0] sleep_word = {8'h00, sleep_ctl_q};

    // unmapped addresses and write commands answer zero on the next word
    wire [15:0] rd_value =
        rd_sleep ? sleep_word :
        rd_flags ? flags_q :
        rd_lot1 ? LOT_FIRST :
        rd_lot2 ? LOT_SECOND :
        rd_lot3 ? LOT_THIRD :
        rd_part ? PART_CODE :
        rd_serial ? serial_word :
        16'h0000;

    always_comb begin
        tx_d = tx_q;
        if (spi.word_valid) begin
            tx_d = cmd_write ? 16'h0000 : rd_value;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 16'h0000;
        end else begin
            tx_q <= tx_d;
        end
    end
    assign spi.tx_word = tx_q;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_ctl_q <= ssi_pkg::SLEEP_CONTROL_RST;
        end else if (sleep_wr) begin
            sleep_ctl_q <= cmd_data;
        end
    end

    // error conditions, sampled at the end of each sample cycle
    always_comb begin
        flag_cond = 16'h0000;
        flag_cond[ssi_pkg::FLAG_FLASH_UPDATE] = i_flash_fail;
        flag_cond[ssi_pkg::FLAG_OVERRANGE] = i_overrange;
        flag_cond[ssi_pkg::FLAG_SELF_TEST] = i_self_test_fail;
        flag_cond[ssi_pkg::FLAG_CHECKSUM] = i_checksum_fail;
        flag_cond[ssi_pkg::FLAG_ALARM1] = i_alarm1;
        flag_cond[ssi_pkg::FLAG_ALARM2] = i_alarm2;
    end

    always_comb begin
        flag_set = flag_cond & {16{i_sample_tick}};
        flag_set[ssi_pkg::FLAG_SPI_FAIL] = spi.frame_err;
    end

    // a set in the clearing cycle survives, so no event is lost
    genvar b;
    for (b = 0; b < 16; b++) begin : g_flag
        if (b == ssi_pkg::FLAG_SUPPLY_LOW) begin : g_follow
            assign flags_d[b] = i_supply_low;
        end else if (ssi_pkg::FAULT_FLAGS_USED[b]) begin : g_sticky
            assign flags_d[b] = flag_set[b]
                | (flags_q[b] & ~flags_rd);
        end else begin : g_unused
            assign flags_d[b] = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= ssi_pkg::FAULT_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign o_fault_flags = flags_q;

    ssi_sleep_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_start(sleep_timed_go),
        .i_steps(cmd_data),
        .i_cancel(spi.cs_fall),
        .o_done(timer_done)
    );

    // chip select wakes either sleep; reset pin and power-up reset us
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            AWAKE: begin
                if (sleep_wr && sleep_forever) begin
                    pwr_d = SLEEP_HOLD;
                end else if (sleep_timed_go) begin
                    pwr_d = SLEEP_TIMED;
                end
            end
            SLEEP_HOLD: begin
                if (spi.cs_fall) begin
                    pwr_d = AWAKE;
                end
            end
            SLEEP_TIMED: begin
                if (spi.cs_fall || timer_done) begin
                    pwr_d = AWAKE;
                end
            end
            default: begin
                pwr_d = AWAKE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= AWAKE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sleep <= 1'b0;
        end else begin
            o_sleep <= (pwr_d != AWAKE);
        end
    end
endmodule : ssi_regs

// ### hdl/ssi_pkg.sv
// shared constants for the sleep, status and identification register bank
package ssi_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int SLEEP_STEP_MS = 500;
    localparam int SLEEP_STEP_CYCLES = CLK_HZ / 1000 * SLEEP_STEP_MS;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 7;
    localparam int FRAME_BITS = 16;

    localparam logic [6:0] SLEEP_CONTROL_OFS = 7'h24;
    localparam logic [6:0] FAULT_FLAGS_OFS = 7'h26;
    localparam logic [6:0] LOT_CODE_FIRST_OFS = 7'h32;
    localparam logic [6:0] LOT_CODE_SECOND_OFS = 7'h34;
    localparam logic [6:0] LOT_CODE_THIRD_OFS = 7'h36;
    localparam logic [6:0] PART_NUMBER_OFS = 7'h38;
    localparam logic [6:0] UNIT_SERIAL_OFS = 7'h3a;

    localparam logic [7:0] SLEEP_FOREVER = 8'hff;
    localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
    localparam logic [15:0] FAULT_FLAGS_RST = 16'h0000;
    localparam logic [15:0] FAULT_FLAGS_USED = 16'h037d;

    localparam int FLAG_SUPPLY_LOW = 0;
    localparam int FLAG_FLASH_UPDATE = 2;
    localparam int FLAG_SPI_FAIL = 3;
    localparam int FLAG_OVERRANGE = 4;
    localparam int FLAG_SELF_TEST = 5;
    localparam int FLAG_CHECKSUM = 6;
    localparam int FLAG_ALARM1 = 8;
    localparam int FLAG_ALARM2 = 9;
    localparam int SERIAL_W = 14;

    // pin stage order: sclk, cs_n, din
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_DIN = 2;
    localparam logic [2:0] PIN_IDLE = 3'h3;
endpackage : ssi_pkg

// ### hdl/ssi_spi_if.sv
// carrier between the serial frontend and the register core
`timescale 1ns/1ps
interface ssi_spi_if;
    logic word_valid;
    logic [15:0] word;
    logic frame_err;
    logic cs_fall;
    logic [15:0] tx_word;
    modport slave (
        output word_valid,
        output word,
        output frame_err,
        output cs_fall,
        input tx_word
    );
    modport core (
        input word_valid,
        input word,
        input frame_err,
        input cs_fall,
        output tx_word
    );
endinterface : ssi_spi_if

// ### hdl/ssi_spi_slave.sv
// oversampled spi mode 3 slave with 16-bit word framing
`timescale 1ns/1ps
module ssi_spi_slave (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe_n,
    ssi_spi_if.slave bus
);
    logic [2:0] pins;
    logic [2:0] s1_q, s2_q, s3_q, stab_q, prev_q;
    logic [3:0] cnt_q;
    logic [15:0] rx_q, tx_q;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, word_done;

    assign pins = {i_din, i_cs_n, i_sclk};

    // a pin change counts only once the second and third stages agree
    genvar g;
    for (g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                s1_q[g] <= ssi_pkg::PIN_IDLE[g];
                s2_q[g] <= ssi_pkg::PIN_IDLE[g];
                s3_q[g] <= ssi_pkg::PIN_IDLE[g];
                stab_q[g] <= ssi_pkg::PIN_IDLE[g];
                prev_q[g] <= ssi_pkg::PIN_IDLE[g];
            end else begin
                s1_q[g] <= pins[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                stab_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : stab_q[g];
                prev_q[g] <= stab_q[g];
            end
        end
    end

    wire sel = ~stab_q[ssi_pkg::PIN_CS_N];
    assign sclk_rise = sel & stab_q[ssi_pkg::PIN_SCLK]
        & ~prev_q[ssi_pkg::PIN_SCLK];
    assign sclk_fall = sel & ~stab_q[ssi_pkg::PIN_SCLK]
        & prev_q[ssi_pkg::PIN_SCLK];
    assign cs_fall = sel & prev_q[ssi_pkg::PIN_CS_N];
    assign cs_rise = ~sel & ~prev_q[ssi_pkg::PIN_CS_N];
    assign word_done = sclk_rise && (cnt_q == 4'hf);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 4'h0;
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
        end else begin
            if (cs_fall || cs_rise) begin
                cnt_q <= 4'h0;
            end else if (sclk_rise) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (sclk_rise) begin
                rx_q <= {rx_q[14:0], stab_q[ssi_pkg::PIN_DIN]};
            end
            // answer to the previous word starts at chip select or word edge
            if (cs_fall || (sclk_fall && cnt_q == 4'h0)) begin
                tx_q <= bus.tx_word;
            end else if (sclk_fall) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.word_valid <= 1'b0;
            bus.word <= 16'h0000;
            bus.frame_err <= 1'b0;
            bus.cs_fall <= 1'b0;
        end else begin
            bus.word_valid <= word_done;
            if (word_done) begin
                bus.word <= {rx_q[14:0], stab_q[ssi_pkg::PIN_DIN]};
            end
            bus.frame_err <= cs_rise && (cnt_q != 4'h0);
            bus.cs_fall <= cs_fall;
        end
    end

    assign o_dout = tx_q[15];
    assign o_dout_oe_n = ~sel;
endmodule : ssi_spi_slave

// ### hdl/ssi_sleep_timer.sv
// half-second step timer for timed sleep
`timescale 1ns/1ps
module ssi_sleep_timer #(
    parameter int STEP_CYCLES = ssi_pkg::SLEEP_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [7:0] i_steps,
    input wire logic i_cancel,
    output logic o_done
);
    logic [31:0] pre_q;
    logic [7:0] left_q;
    logic run_q;
    wire step_end = (pre_q == 32'(STEP_CYCLES - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_q <= 32'h0;
            left_q <= 8'h00;
            run_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                pre_q <= 32'h0;
                left_q <= i_steps;
                run_q <= 1'b1;
            end else if (i_cancel) begin
                run_q <= 1'b0;
            end else if (run_q && left_q == 8'h00) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end else if (run_q) begin
                pre_q <= step_end ? 32'h0 : pre_q + 32'h1;
                if (step_end) begin
                    left_q <= left_q - 8'h01;
                end
            end
        end
    end
endmodule : ssi_sleep_timer

// ### bench/ssi_host_model.sv
// spi mode 3 host model driving the register bank pins
`timescale 1ns/1ps
module ssi_host_model (
    input wire logic i_clk,
    input wire logic i_dout,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    // keeps each sclk level well above the two-clock minimum
    localparam int HALF = 6;
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    // a count below 16 leaves a partial frame on purpose
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (HALF) @(negedge i_clk);
        for (int i = 0; i < nbits; i++) begin
            o_sclk = 1'b0;
            o_din = tx[15-i];
            repeat (HALF) @(negedge i_clk);
            // capture before the rising edge, while o_dout is settled
            rx = {rx[14:0], i_dout};
            o_sclk = 1'b1;
            repeat (HALF) @(negedge i_clk);
        end
        o_cs_n = 1'b1;
        // released line must not keep its last level
        o_din = ~o_din;
        repeat (2 * HALF) @(negedge i_clk);
    endtask : xfer
endmodule : ssi_host_model

// ### bench/ssi_regs_chk.sv
// assertions on the register bank ports
`timescale 1ns/1ps
module ssi_regs_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sample_tick,
    input wire logic i_supply_low,
    input wire logic i_self_test_fail,
    input wire logic i_alarm1,
    input wire logic o_dout_oe_n,
    input wire logic o_sleep,
    input wire logic [15:0] o_fault_flags
);
    logic [2:0] up_cnt_q;
    logic [2:0] up_cnt_d;
    logic settled;
    logic st_hit;
    // saturates, so the guard stays open until the next reset
    assign up_cnt_d = (up_cnt_q == 3'h7) ? up_cnt_q : up_cnt_q + 3'h1;
    assign settled = (up_cnt_q >= 3'h4);
    assign st_hit = i_sample_tick & i_self_test_fail;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_cnt_q <= 3'h0;
        end else begin
            up_cnt_q <= up_cnt_d;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence cs_fall;
        $fell(i_cs_n);
    endsequence
    reset_clear_a: assert property (
        $rose(i_rst_n) |-> o_fault_flags == 16'h0000 && !o_sleep)
        else $error("flags or sleep not clear after reset");
    unused_zero_a: assert property (
        (o_fault_flags & 16'hfc82) == 16'h0000)
        else $error("unused flag bit set");
    supply_follow_a: assert property (
        settled |-> o_fault_flags[0] == $past(i_supply_low))
        else $error("supply low bit does not follow monitor");
    alarm_set_a: assert property (
        settled && i_sample_tick && i_alarm1 |-> ##[1:2] o_fault_flags[8])
        else $error("first alarm flag not set after sample");
    selftest_cause_a: assert property (
        $rose(o_fault_flags[5]) |-> $past(st_hit) || $past(st_hit, 2))
        else $error("self-test flag set without cause");
    cs_wake_a: assert property (
        cs_fall |-> ##[1:8] !o_sleep)
        else $error("chip select fall did not wake");
    oe_active_a: assert property (
        cs_fall |-> ##[2:6] !o_dout_oe_n)
        else $error("data out not enabled after select");
    oe_idle_a: assert property (
        i_cs_n [*6] |-> o_dout_oe_n)
        else $error("data out enabled while deselected");
endmodule : ssi_regs_chk
bind ssi_regs ssi_regs_chk u_ssi_regs_chk (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n),
    .i_sample_tick(i_sample_tick),
    .i_supply_low(i_supply_low),
    .i_self_test_fail(i_self_test_fail),
    .i_alarm1(i_alarm1),
    .o_dout_oe_n(o_dout_oe_n),
    .o_sleep(o_sleep),
    .o_fault_flags(o_fault_flags)
);

// ### bench/ssi_regs_tb.sv
// self-checking bench for the sleep, status and identification registers
`timescale 1ns/1ps
module ssi_regs_tb;
    localparam int STEP = 40;
    localparam logic [15:0] PART = 16'h5a5a; // arbitrary value
    localparam logic [13:0] SERIAL = 14'h270f;
    localparam logic [6:0] FLG = ssi_pkg::FAULT_FLAGS_OFS;
    localparam logic [5:0][6:0] ID_OFS = {7'h32, 7'h34, 7'h36,
        ssi_pkg::PART_NUMBER_OFS, ssi_pkg::UNIT_SERIAL_OFS, 7'h40};
    localparam logic [5:0][15:0] ID_VAL = {16'h1111, 16'h2222,
        16'h3333, PART, {2'b00, SERIAL}, 16'h0000};
    logic clk, rst_n, sclk, cs_n, din, tick, sup_low, dout, dout_oe_n;
    logic sleep;
    logic [5:0] cond; // flash, overrange, self-test, checksum, alarm1, 2
    logic [15:0] flags, rx;
    int n_errors, check_count, waited;
    ssi_regs #(.STEP_CYCLES(STEP), .PART_CODE(PART),
        .LOT_FIRST(16'h1111), .LOT_SECOND(16'h2222),
        .LOT_THIRD(16'h3333), .SERIAL_CODE(SERIAL)) u_ssi_regs (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_sample_tick(tick), .i_supply_low(sup_low),
        .i_flash_fail(cond[0]), .i_overrange(cond[1]),
        .i_self_test_fail(cond[2]), .i_checksum_fail(cond[3]),
        .i_alarm1(cond[4]), .i_alarm2(cond[5]), .o_dout(dout),
        .o_dout_oe_n(dout_oe_n), .o_sleep(sleep), .o_fault_flags(flags));
    ssi_host_model u_ssi_host_model (.i_clk(clk), .i_dout(dout),
        .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [6:0] ofs, input logic [7:0] data);
        u_ssi_host_model.xfer({1'b1, ofs, data}, 16, rx);
    endtask : wr
    // the answer rides on the following word
    task automatic rd(input logic [6:0] ofs, output logic [15:0] data);
        u_ssi_host_model.xfer({1'b0, ofs, 8'h00}, 16, rx);
        u_ssi_host_model.xfer(16'h0000, 16, data);
    endtask : rd
    task automatic pulse_tick();
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse_tick
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("mismatch watchdog expected done seen hang");
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        tick = 1'b0;
        sup_low = 1'b0;
        cond = 6'h00;
        n_errors = 0;
        check_count = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        rd(FLG, rx);
        check("flags reset", 16'h0000, rx);
        for (int i = 5; i >= 0; i--) begin
            rd(ID_OFS[i], rx);
            check("ident", ID_VAL[i], rx);
        end
        wr(ssi_pkg::PART_NUMBER_OFS, 8'h00);
        rd(ssi_pkg::PART_NUMBER_OFS, rx);
        check("part after write", PART, rx);
        $display("test ident done");
        cond = 6'h3f;
        sup_low = 1'b1;
        pulse_tick();
        rd(FLG, rx);
        check("flags set", 16'h0375, rx);
        rd(FLG, rx);
        check("flags cleared", 16'h0001, rx);
        pulse_tick();
        rd(FLG, rx);
        check("flags again", 16'h0375, rx);
        sup_low = 1'b0;
        cond = 6'h00;
        repeat (4) @(negedge clk);
        check("supply bit", 16'h0000, {15'h0000, flags[0]});
        $display("test flags done");
        u_ssi_host_model.xfer(16'h0000, 12, rx);
        rd(FLG, rx);
        check("spi fail", 16'h0008, rx);
        rd(FLG, rx);
        check("spi clean", 16'h0000, rx);
        $display("test framing done");
        wr(7'h25, 8'hff);
        check("upper byte", 16'h0000, {15'h0000, sleep});
        wr(ssi_pkg::SLEEP_CONTROL_OFS, 8'hff);
        repeat (200) @(negedge clk);
        check("sleep forever", 16'h0001, {15'h0000, sleep});
        u_ssi_host_model.xfer(16'h0000, 16, rx);
        check("cs wake", 16'h0000, {15'h0000, sleep});
        wr(ssi_pkg::SLEEP_CONTROL_OFS, 8'hff);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check("reset wake", 16'h0000, {15'h0000, sleep});
        $display("test sleep done");
        wr(ssi_pkg::SLEEP_CONTROL_OFS, 8'h03);
        check("timed start", 16'h0001, {15'h0000, sleep});
        waited = 0;
        while (sleep !== 1'b0 && waited < 1000) begin
            @(negedge clk);
            waited++;
        end
        check("timed len", 16'h0001,
              {15'h0000, waited > 3 * STEP - 40 && waited <= 3 * STEP});
        $display("test timed sleep done");
        wr(ssi_pkg::SLEEP_CONTROL_OFS, 8'hfe);
        check("long sleep", 16'h0001, {15'h0000, sleep});
        rd(ssi_pkg::SLEEP_CONTROL_OFS, rx);
        check("sleep readback", 16'h00fe, rx);
        check("timed cs wake", 16'h0000, {15'h0000, sleep});
        $display("test sleep cancel done");
        print_verdict();
    end
endmodule : ssi_regs_tb
